//--- common/sbt_params.svh
// Constants of the SRAM boundary-scan test port
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH
`define SBT_IR_W 3
`define SBT_IR_EXTEST 3'h0
`define SBT_IR_IDCODE 3'h1
`define SBT_IR_SAMPLE_Z 3'h2
`define SBT_IR_SAMPLE 3'h4
`define SBT_IR_BYPASS 3'h7
`define SBT_IR_CAPTURE 3'h1
`define SBT_Q_W 18
`define SBT_BSR_LEN 109
`define SBT_CTRL_BIT 48
`define SBT_CQ_BIT 18
`define SBT_CQN_BIT 19
`define SBT_ID_W 32
`define SBT_SYNC_RST 2'h0
`endif

//--- common/sbt_pkg.sv
// Types of the SRAM boundary-scan test port
`include "sbt_params.svh"
package sbt_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
  } sbt_tap_e;

  // One value for each output pad group: read data and both echo clocks
  typedef struct packed {
    logic [`SBT_Q_W-1:0] q;
    logic cq;
    logic cqn;
  } sbt_pads_s;
endpackage

//--- hw/sbt_tap.sv
// Boundary-scan test access port of a DDR SRAM, sampled on the system clock
//
// Contract
// - Instruction codes: 000 extest, 001 idcode, 010 sample-z, 100 sample, 111 bypass.
// - Sample-z floats read data and echo clocks and captures pad values.
// - Output control comes from boundary register bit 48.
// - Control bit latches only in Update-DR under extest or sample.
// - Extest drives update data on echo clocks; on read data only if control is 1.
// - Idcode, sample and bypass leave normal SRAM output on the pins.
// - Extest and sample-z capture pad levels of echo clocks and read data.
// - Sample captures internal echo clocks; read data internal when reading, else pad.
// - Idcode is the instruction after reset and in Test-Logic-Reset.
// - Bypass puts the one-bit bypass register between TDI and TDO in Shift-DR.
`timescale 1ns/1ps
`include "sbt_params.svh"
module sbt_tap #(
  parameter int BSR_LEN = `SBT_BSR_LEN,
  parameter logic [`SBT_ID_W-1:0] ID_VALUE = 32'h0000_0001 // Arbitrary identity value
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  input wire sbt_pkg::sbt_pads_s sram_out_in,
  input wire logic sram_read_in,
  input wire sbt_pkg::sbt_pads_s pad_in,
  output sbt_pkg::sbt_pads_s pad_out,
  output logic q_oe_out,
  output logic echo_oe_out,
  output logic [`SBT_IR_W-1:0] instr_out
);

  localparam int PW = `SBT_Q_W + 2;

  logic [1:0] rst_sync_ff;
  logic rst_b;
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic tck_prev_ff;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  sbt_pkg::sbt_pads_s pad_s1_ff;
  sbt_pkg::sbt_pads_s pad_s2_ff;
  sbt_pkg::sbt_tap_e state_ff;
  sbt_pkg::sbt_tap_e nxt_state;
  logic [`SBT_IR_W-1:0] ir_shift_ff;
  logic [`SBT_IR_W-1:0] ir_ff;
  logic bypass_ff;
  logic [`SBT_ID_W-1:0] id_ff;
  logic [BSR_LEN-1:0] bsr_ff;
  logic [BSR_LEN-1:0] upd_ff;
  logic [BSR_LEN-1:0] bsr_cap;
  logic tdo_ff;
  logic tdo_oe_ff;
  logic serial_out;
  logic is_extest;
  logic is_samplez;
  logic is_sample;
  logic is_idcode;
  sbt_pkg::sbt_pads_s cap_src;
  sbt_pkg::sbt_pads_s upd_pads;
  sbt_pkg::sbt_pads_s pad_ff;
  logic q_oe_ff;
  logic echo_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  // Reset asserts at once but releases through two flops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_ff <= `SBT_SYNC_RST;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_ff[1];

  // TCK, TMS, TDI and pads come from another domain; two flops before use
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
      tck_prev_ff <= 1'b0;
      pad_s1_ff <= '0;
      pad_s2_ff <= '0;
    end else begin
      pin_s1_ff <= {tck_in, tms_in, tdi_in};
      pin_s2_ff <= pin_s1_ff;
      tck_prev_ff <= pin_s2_ff[2];
      pad_s1_ff <= pad_in;
      pad_s2_ff <= pad_s1_ff;
    end
  end

  // A clock held low (unused port) gives no edges and leaves the TAP idle
  assign tck_rise = pin_s2_ff[2] && !tck_prev_ff;
  assign tck_fall = !pin_s2_ff[2] && tck_prev_ff;
  assign tms = pin_s2_ff[1];
  assign tdi = pin_s2_ff[0];

  ////////////////////////////////////////////////////////////////////////////
  // TAP controller

  // Standard sixteen-state walk, TMS taken at the rising test clock
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sbt_pkg::TLR: nxt_state = tms ? sbt_pkg::TLR : sbt_pkg::RTI;
      sbt_pkg::RTI: nxt_state = tms ? sbt_pkg::SEL_DR : sbt_pkg::RTI;
      sbt_pkg::SEL_DR: nxt_state = tms ? sbt_pkg::SEL_IR : sbt_pkg::CAP_DR;
      sbt_pkg::CAP_DR: nxt_state = tms ? sbt_pkg::EX1_DR : sbt_pkg::SH_DR;
      sbt_pkg::SH_DR: nxt_state = tms ? sbt_pkg::EX1_DR : sbt_pkg::SH_DR;
      sbt_pkg::EX1_DR: nxt_state = tms ? sbt_pkg::UPD_DR : sbt_pkg::PAU_DR;
      sbt_pkg::PAU_DR: nxt_state = tms ? sbt_pkg::EX2_DR : sbt_pkg::PAU_DR;
      sbt_pkg::EX2_DR: nxt_state = tms ? sbt_pkg::UPD_DR : sbt_pkg::SH_DR;
      sbt_pkg::UPD_DR: nxt_state = tms ? sbt_pkg::SEL_DR : sbt_pkg::RTI;
      sbt_pkg::SEL_IR: nxt_state = tms ? sbt_pkg::TLR : sbt_pkg::CAP_IR;
      sbt_pkg::CAP_IR: nxt_state = tms ? sbt_pkg::EX1_IR : sbt_pkg::SH_IR;
      sbt_pkg::SH_IR: nxt_state = tms ? sbt_pkg::EX1_IR : sbt_pkg::SH_IR;
      sbt_pkg::EX1_IR: nxt_state = tms ? sbt_pkg::UPD_IR : sbt_pkg::PAU_IR;
      sbt_pkg::PAU_IR: nxt_state = tms ? sbt_pkg::EX2_IR : sbt_pkg::PAU_IR;
      sbt_pkg::EX2_IR: nxt_state = tms ? sbt_pkg::UPD_IR : sbt_pkg::SH_IR;
      sbt_pkg::UPD_IR: nxt_state = tms ? sbt_pkg::SEL_DR : sbt_pkg::RTI;
      default: nxt_state = sbt_pkg::TLR;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= sbt_pkg::TLR;
    end else if (tck_rise) begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      ir_shift_ff <= `SBT_IR_CAPTURE;
      ir_ff <= `SBT_IR_IDCODE;
    end else if (tck_rise) begin
      case (state_ff)
        sbt_pkg::TLR: ir_ff <= `SBT_IR_IDCODE;
        sbt_pkg::CAP_IR: ir_shift_ff <= `SBT_IR_CAPTURE;
        sbt_pkg::SH_IR: ir_shift_ff <= {tdi, ir_shift_ff[`SBT_IR_W-1:1]};
        sbt_pkg::UPD_IR: ir_ff <= ir_shift_ff;
        default: ir_ff <= ir_ff;
      endcase
    end
  end

  // Reserved codes are not expected; they fall to bypass behaviour
  assign is_extest = (ir_ff == `SBT_IR_EXTEST);
  assign is_idcode = (ir_ff == `SBT_IR_IDCODE);
  assign is_samplez = (ir_ff == `SBT_IR_SAMPLE_Z);
  assign is_sample = (ir_ff == `SBT_IR_SAMPLE);
  assign instr_out = ir_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Data registers

  // Capture source of the output cells depends on instruction and SRAM state
  always_comb begin
    cap_src = pad_s2_ff;
    if (is_sample) begin
      cap_src.cq = sram_out_in.cq;
      cap_src.cqn = sram_out_in.cqn;
      cap_src.q = sram_read_in ? sram_out_in.q : pad_s2_ff.q;
    end
  end

  // Output cells take the chosen source; other cells keep their value
  always_comb begin
    bsr_cap = bsr_ff;
    bsr_cap[PW-1:0] = {cap_src.cqn, cap_src.cq, cap_src.q};
  end

  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      bypass_ff <= 1'b0;
      id_ff <= '0;
      bsr_ff <= '0;
    end else if (tck_rise) begin
      case (state_ff)
        sbt_pkg::CAP_DR: begin
          bypass_ff <= 1'b0;
          id_ff <= ID_VALUE;
          bsr_ff <= bsr_cap;
        end
        sbt_pkg::SH_DR: begin
          bypass_ff <= tdi;
          if (is_idcode) begin
            id_ff <= {tdi, id_ff[`SBT_ID_W-1:1]};
          end
          if (is_extest || is_sample || is_samplez) begin
            bsr_ff <= {tdi, bsr_ff[BSR_LEN-1:1]};
          end
        end
        default: bypass_ff <= bypass_ff;
      endcase
    end
  end

  // Update stage, control bit included, loads only under extest or sample
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      upd_ff <= '0;
    end else if (tck_rise && state_ff == sbt_pkg::UPD_DR && (is_extest || is_sample)) begin
      upd_ff <= bsr_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test data out

  // Serial source follows the instruction; unknown codes act as bypass
  always_comb begin
    serial_out = bypass_ff;
    if (state_ff == sbt_pkg::SH_IR) begin
      serial_out = ir_shift_ff[0];
    end else if (is_idcode) begin
      serial_out = id_ff[0];
    end else if (is_extest || is_sample || is_samplez) begin
      serial_out = bsr_ff[0];
    end
  end

  // TDO moves only on the falling test clock, giving the far end half a period
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else if (tck_fall) begin
      tdo_ff <= serial_out;
      tdo_oe_ff <= (state_ff == sbt_pkg::SH_DR) || (state_ff == sbt_pkg::SH_IR);
    end
  end
  assign tdo_out = tdo_ff;
  assign tdo_oe_out = tdo_oe_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Output pad control

  assign upd_pads.q = upd_ff[`SBT_Q_W-1:0];
  assign upd_pads.cq = upd_ff[`SBT_CQ_BIT];
  assign upd_pads.cqn = upd_ff[`SBT_CQN_BIT];

  // Registered pad drive; costs one system clock of latency on the SRAM path
  always_ff @(posedge clk_in or negedge rst_b) begin
    if (!rst_b) begin
      pad_ff <= '0;
      q_oe_ff <= 1'b0;
      echo_oe_ff <= 1'b0;
    end else if (is_extest) begin
      pad_ff <= upd_pads;
      echo_oe_ff <= 1'b1;
      q_oe_ff <= upd_ff[`SBT_CTRL_BIT];
    end else if (is_samplez) begin
      pad_ff <= sram_out_in;
      echo_oe_ff <= 1'b0;
      q_oe_ff <= 1'b0;
    end else begin
      pad_ff <= sram_out_in;
      echo_oe_ff <= 1'b1;
      q_oe_ff <= sram_read_in;
    end
  end
  assign pad_out = pad_ff;
  assign q_oe_out = q_oe_ff;
  assign echo_oe_out = echo_oe_ff;

endmodule

//--- test/sbt_tap_properties.sv
// Concurrent checks on the pins of the boundary-scan test port
`timescale 1ns/1ps
`include "sbt_params.svh"
module sbt_tap_properties (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic tck_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_out,
  input wire sbt_pkg::sbt_pads_s sram_out_in,
  input wire logic sram_read_in,
  input wire sbt_pkg::sbt_pads_s pad_out,
  input wire logic q_oe_out,
  input wire logic echo_oe_out,
  input wire logic [`SBT_IR_W-1:0] instr_out
);
  logic [1:0] live_cnt_ff;
  logic live;
  // Pad checks wait out the two-flop reset release plus one pipeline stage
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      live_cnt_ff <= 2'h0;
    end else if (live_cnt_ff != 2'h3) begin
      live_cnt_ff <= live_cnt_ff + 2'h1;
    end
  end
  assign live = (live_cnt_ff == 2'h3);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////
  sequence s_release; $rose(rst_b_in); endsequence
  sequence s_tck_quiet; !tck_in [*6]; endsequence
  sequence s_normal;
    live && (instr_out == `SBT_IR_IDCODE || instr_out == `SBT_IR_SAMPLE || instr_out == `SBT_IR_BYPASS);
  endsequence
  // Pads one clock behind the SRAM side, since the pad drive is registered
  sequence s_follow;
    echo_oe_out && q_oe_out == $past(sram_read_in) && pad_out == $past(sram_out_in);
  endsequence
  AST_RST_IR: assert property (s_release |-> instr_out == `SBT_IR_IDCODE && !echo_oe_out && !tdo_oe_out)
    else $error("instruction or enables wrong at reset release");
  AST_WAKE_DRIVE: assert property (s_release |-> ##[1:6] echo_oe_out)
    else $error("echo clocks not driven after reset");
  AST_NORMAL_DRIVE: assert property (s_normal |=> s_follow)
    else $error("pads do not carry the SRAM output");
  AST_EXTEST_ECHO: assert property (live && instr_out == `SBT_IR_EXTEST |=> echo_oe_out)
    else $error("echo clocks not driven under extest");
  AST_SAMPZ_FLOAT: assert property (live && instr_out == `SBT_IR_SAMPLE_Z |=> !echo_oe_out && !q_oe_out)
    else $error("pads not floated under sample-z");
  AST_OE_PAIR: assert property (live |-> echo_oe_out || !q_oe_out)
    else $error("read data driven with echo clocks floated");
  AST_TDO_EDGE: assert property ($changed(tdo_out) || $changed(tdo_oe_out) |-> $past(tck_in, 2) == 1'b0)
    else $error("test data out moved while test clock high");
  AST_IR_QUIET: assert property (s_tck_quiet ##0 live |=> $stable(instr_out))
    else $error("instruction changed with test clock idle");
endmodule
bind sbt_tap sbt_tap_properties u_props (.clk_in(clk_in), .rst_b_in(rst_b_in), .tck_in(tck_in),
  .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .sram_out_in(sram_out_in), .sram_read_in(sram_read_in),
  .pad_out(pad_out), .q_oe_out(q_oe_out), .echo_oe_out(echo_oe_out), .instr_out(instr_out));

//--- test/sbt_jtag_ctrl.sv
// Behavioural boundary-scan controller driving the test port pins
`timescale 1ns/1ps
module sbt_jtag_ctrl (
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  input wire logic tdo_in
);
  // Test clock parked low outside scans so the port stays inactive
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  // One 200 ns period; TDO read just before the fall, where it is settled
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    #100 tck_out = 1'b1;
    #95 tdo = tdo_in;
    #5 tck_out = 1'b0;
  endtask
  // Five highs reach Test-Logic-Reset from anywhere, then park in Run-Test/Idle
  task automatic reset_tap();
    logic b;
    repeat (5) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
  // Idle to idle scan, LSB first; only defined codes are ever loaded
  task automatic scan(input logic ir, input logic [108:0] din, input int n, output logic [108:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b1, b);
    if (ir) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
endmodule

//--- test/tb_top.sv
// Self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
`include "sbt_params.svh"
module tb_top;
  localparam logic [31:0] ID = 32'h0000_00a5; // Arbitrary identity value
  typedef struct packed {logic [2:0] code; logic rd; logic echo; logic q; logic norm;} sbt_row_s;
  sbt_row_s rows [4] = '{'{`SBT_IR_IDCODE, 1'b1, 1'b1, 1'b1, 1'b1}, '{`SBT_IR_SAMPLE, 1'b0, 1'b1, 1'b0, 1'b1},
    '{`SBT_IR_BYPASS, 1'b1, 1'b1, 1'b1, 1'b1}, '{`SBT_IR_SAMPLE_Z, 1'b1, 1'b0, 1'b0, 1'b0}};
  logic clk_in, rst_b_in, tck, tms, tdi, tdo, tdo_oe, sram_read, q_oe, echo_oe;
  logic tdo_pin;
  logic [2:0] instr;
  logic [108:0] d, din;
  logic [19:0] exp_c;
  sbt_pkg::sbt_pads_s sram_out, pad_in, pad_out;
  int failures = 0;
  int cmp_count = 0;
  sbt_tap #(.ID_VALUE(ID)) uut (.clk_in(clk_in), .rst_b_in(rst_b_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .tdo_out(tdo), .tdo_oe_out(tdo_oe), .sram_out_in(sram_out), .sram_read_in(sram_read), .pad_in(pad_in),
    .pad_out(pad_out), .q_oe_out(q_oe), .echo_oe_out(echo_oe), .instr_out(instr));
  // Undriven TDO reads as the inverse of its last value, so a read outside a shift state fails
  assign tdo_pin = tdo_oe ? tdo : ~tdo;
  sbt_jtag_ctrl ctl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_pin));
  ////////////////////////////////////////////////////////////
  // Shared compare and verdict
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d failures=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Boundary cells 0..17 hold read data, then the two echo clocks
  function automatic logic [19:0] cells(sbt_pkg::sbt_pads_s p);
    return {p.cqn, p.cq, p.q};
  endfunction
  task automatic load_ir(input logic [2:0] code);
    ctl.scan(1'b1, {106'h0, code}, 3, d);
    repeat (6) @(negedge clk_in);
  endtask
  ////////////////////////////////////////////////////////////
  // 40 MHz clock; watchdog sized well past the expected run
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  initial begin
    #1500000;
    failures++;
    stop_test();
  end
  initial begin
    rst_b_in = 1'b0;
    sram_read = 1'b0;
    sram_out = 20'ha_5c3e;
    pad_in = 20'h6_c1f9;
    repeat (5) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (4) @(negedge clk_in);
    ctl.reset_tap();
    ctl.scan(1'b0, '0, 32, d);
    chk(d[31:0], ID);
    // Instruction table: pins must follow the decoded instruction
    foreach (rows[i]) begin
      sram_read = rows[i].rd;
      ctl.scan(1'b1, {106'h0, rows[i].code}, 3, d);
      chk(d[2:0], 3'h1);
      repeat (6) @(negedge clk_in);
      chk(instr, rows[i].code);
      chk({echo_oe, q_oe}, {rows[i].echo, rows[i].q});
      if (rows[i].norm) chk(pad_out, sram_out);
    end
    // Preload with output control set, then drive it under extest
    din = '0;
    din[19:0] = 20'hb_5a3c;
    din[48] = 1'b1;
    load_ir(`SBT_IR_SAMPLE);
    ctl.scan(1'b0, din, 109, d);
    load_ir(`SBT_IR_EXTEST);
    chk(cells(pad_out), din[19:0]);
    chk({echo_oe, q_oe}, 2'h3);
    // Bypass is one cell, captured as zero; its Update-DR must not touch control
    load_ir(`SBT_IR_BYPASS);
    ctl.scan(1'b0, 109'h1, 2, d);
    chk(d[1:0], 2'h2);
    load_ir(`SBT_IR_EXTEST);
    chk(q_oe, 1'b1);
    din[48] = 1'b0;
    ctl.scan(1'b0, din, 109, d);
    chk(d[19:0], cells(pad_in));
    repeat (6) @(negedge clk_in);
    chk({echo_oe, q_oe}, 2'h2);
    // Capture source by instruction and SRAM state
    for (int k = 0; k < 3; k++) begin
      sram_read = (k == 0);
      load_ir(k < 2 ? `SBT_IR_SAMPLE : `SBT_IR_SAMPLE_Z);
      ctl.scan(1'b0, '0, 20, d);
      exp_c = (k == 0) ? cells(sram_out) : (k == 1) ? {sram_out.cqn, sram_out.cq, pad_in.q} : cells(pad_in);
      chk(d[19:0], exp_c);
    end
    // Reset in mid-run returns to the identity instruction
    rst_b_in = 1'b0;
    @(negedge clk_in);
    chk({instr, echo_oe, q_oe}, {`SBT_IR_IDCODE, 2'h0});
    rst_b_in = 1'b1;
    repeat (4) @(negedge clk_in);
    ctl.reset_tap();
    chk(instr, `SBT_IR_IDCODE);
    // Test-Logic-Reset alone, without the reset pin, must also bring back the identity instruction
    load_ir(`SBT_IR_BYPASS);
    chk(instr, `SBT_IR_BYPASS);
    ctl.reset_tap();
    chk(instr, `SBT_IR_IDCODE);
    stop_test();
  end
endmodule
